/* design/sbcfg_pkg.sv */
/*
 * constants, register map and types shared by the strap and fuse
 * boot-configuration block.
 * assumes a 10 MHz system clock and an APB master with 32-bit data.
 */
package sbcfg_pkg;

	////////////////////////////////////////////////////////////////////
	// timing
	localparam int SBCFG_CLK_HZ      = 10_000_000;
	localparam int SBCFG_T_SETUP_MS  = 0;  // straps valid at enable rise
	localparam int SBCFG_T_HOLD_MS   = 3;  // strap hold after enable high
	// least time, so round up to whole cycles
	localparam int SBCFG_HOLD_CYC    =
		(SBCFG_T_HOLD_MS * SBCFG_CLK_HZ + 999) / 1000;

	////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [11:0] SBCFG_STATUS_OFS = 12'h000;
	localparam logic [11:0] SBCFG_CONFIG_OFS = 12'h004;
	localparam logic [11:0] SBCFG_FUSE_OFS   = 12'h008;
	localparam logic [11:0] SBCFG_SNAP_OFS   = 12'h00C;

	// strap vector positions
	localparam int SBCFG_STRAP_A     = 0;
	localparam int SBCFG_STRAP_B     = 1;
	localparam int SBCFG_STRAP_DBG   = 2;
	localparam int SBCFG_STRAP_SMP   = 3;
	localparam int SBCFG_STRAP_DRV   = 4;
	localparam int SBCFG_STRAP_W     = 5;

	// fuse vector positions
	localparam int SBCFG_FUSE_UART   = 0;  // two bits
	localparam int SBCFG_FUSE_USBDBG = 2;
	localparam int SBCFG_FUSE_USBPRT = 3;
	localparam int SBCFG_FUSE_PADDIS = 4;
	localparam int SBCFG_FUSE_UJTDIS = 5;
	localparam int SBCFG_FUSE_SELEN  = 6;
	localparam int SBCFG_FUSE_W      = 7;
	localparam logic [SBCFG_FUSE_W-1:0] SBCFG_FUSE_RST = 7'h00;

	// status register fields
	localparam int SBCFG_ST_VALID    = 8;
	localparam int SBCFG_ST_REL      = 9;
	localparam int SBCFG_ST_STATE    = 10; // two bits

	// config register fields
	localparam int SBCFG_CF_BOOT     = 0;  // two bits
	localparam int SBCFG_CF_JTAG     = 2;  // two bits
	localparam int SBCFG_CF_UPRT     = 4;
	localparam int SBCFG_CF_USBPRT   = 5;
	localparam int SBCFG_CF_SMP      = 6;
	localparam int SBCFG_CF_DRV      = 7;
	localparam int SBCFG_CF_DL       = 8;  // three bits
	localparam int SBCFG_CF_DBGPIN   = 11; // four bits

	// reset values
	localparam logic [SBCFG_STRAP_W-1:0] SBCFG_STRAP_RST = 5'h00;
	localparam logic       SBCFG_PULLUP_RST = 1'b1;
	localparam logic [2:0] SBCFG_DL_ALL     = 3'h7;
	localparam logic [3:0] SBCFG_DBG_ALL    = 4'hF;

	////////////////////////////////////////////////////////////////////
	// enumerations
	typedef enum logic [1:0] {
		SBCFG_OFF  = 2'b00,
		SBCFG_HOLD = 2'b01,
		SBCFG_RUN  = 2'b10
	} sbcfg_state_t;

	typedef enum logic [1:0] {
		SBCFG_BOOT_RSVD  = 2'b00,
		SBCFG_BOOT_SPI   = 2'b01,
		SBCFG_BOOT_JOINT = 2'b10
	} sbcfg_boot_t;

	typedef enum logic [1:0] {
		SBCFG_JTAG_OFF  = 2'b00,
		SBCFG_JTAG_USB  = 2'b01,
		SBCFG_JTAG_PADS = 2'b10
	} sbcfg_jtag_t;

endpackage

/* design/sbcfg_fuse_bank.sv */
/*
 * one-time programmable configuration fuse bank.
 * assumes the caller raises prog_i for one cycle per program request;
 * bits only go from 0 to 1 until reset_n_i clears them all.
 */
`timescale 1ns/1ps

module sbcfg_fuse_bank
	import sbcfg_pkg::*;
#(
	parameter int W = SBCFG_FUSE_W
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	// programming request
	input  wire logic         prog_i,
	input  wire logic [W-1:0] prog_bits_i,
	// fuse values, registered
	output logic      [W-1:0] fuse_o
);

	typedef struct packed {
		logic [W-1:0] bits;
	} sbcfg_fuse_st_t;

	sbcfg_fuse_st_t st_ff;
	sbcfg_fuse_st_t nxt_st;

	////////////////////////////////////////////////////////////////////
	// programming only ever sets bits, so only reset clears a blown fuse
	always_comb begin
		nxt_st = st_ff;
		if (prog_i) begin
			nxt_st.bits = st_ff.bits | prog_bits_i;
		end
	end

	// unburnt fuses read 0 from power-on
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			st_ff.bits <= W'(SBCFG_FUSE_RST);
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign fuse_o = st_ff.bits;

	////////////////////////////////////////////////////////////////////
	// checks
	property p_fuse_sticky;
		@(posedge clk_i) disable iff (!reset_n_i)
		1'b1 |=> ((~st_ff.bits & $past(st_ff.bits)) == '0);
	endproperty
	a_fuse_sticky: assert property (p_fuse_sticky)
		else $error("programmed fuse bit returned to 0");

endmodule

/* design/sbcfg_top.sv */
/*
 * strap latch and boot configuration decoder with an APB register port.
 * assumes strap pins and chip enable arrive asynchronously from pads,
 * and an APB3 master on the same clock as this block.
 */
`timescale 1ns/1ps

module sbcfg_top
	import sbcfg_pkg::*;
#(
	parameter int HOLD_CYC = SBCFG_HOLD_CYC,
	parameter int AW       = 12
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          reset_n_i,
	// chip enable pad
	input  wire logic          chip_enable_pin_i,
	// strap pads
	input  wire logic          boot_strap_a_i,
	input  wire logic          boot_strap_b_i,
	input  wire logic          debug_source_strap_i,
	input  wire logic          sdio_sample_edge_strap_i,
	input  wire logic          sdio_drive_edge_strap_i,
	// pad control
	output logic               boot_strap_b_pull_up_o,
	output logic               gpio_release_o,
	// decoded boot configuration
	output logic               config_valid_o,
	output logic [1:0]         boot_mode_o,
	output logic [2:0]         download_paths_o,
	output logic               sdio_sample_rise_o,
	output logic               sdio_drive_rise_o,
	output logic               uart_print_en_o,
	output logic               usb_print_en_o,
	output logic [1:0]         jtag_source_o,
	output logic [3:0]         debug_pins_en_o,
	// APB slave
	input  wire logic          psel_i,
	input  wire logic          penable_i,
	input  wire logic          pwrite_i,
	input  wire logic [AW-1:0] paddr_i,
	input  wire logic [31:0]   pwdata_i,
	output logic               pready_o,
	output logic [31:0]        prdata_o,
	output logic               pslverr_o
);

	localparam int CW = (HOLD_CYC < 2) ? 1 : $clog2(HOLD_CYC);
	localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYC - 1);

	typedef struct packed {
		logic                     en_meta;
		logic                     en_sync;
		logic [SBCFG_STRAP_W-1:0] pin_meta;
		logic [SBCFG_STRAP_W-1:0] pin_sync;
		sbcfg_state_t             state;
		logic [CW-1:0]            hold_cnt;
		logic [SBCFG_STRAP_W-1:0] strap;
		logic [SBCFG_FUSE_W-1:0]  fuse_snap;
		logic                     valid;
		logic                     release_io;
		logic                     pull_up_b;
		sbcfg_boot_t              boot;
		logic [2:0]               dl;
		logic                     smp;
		logic                     drv;
		logic                     uprt;
		logic                     usbprt;
		sbcfg_jtag_t              jtag;
		logic [3:0]               dbgpin;
		logic                     pready;
		logic [31:0]              prdata;
		logic                     pslverr;
	} sbcfg_st_t;

	sbcfg_st_t                st_ff;
	sbcfg_st_t                nxt_st;
	logic [SBCFG_FUSE_W-1:0]  fuse_q;
	logic                     fuse_prog;
	logic                     apb_done;
	logic [31:0]              status_w;
	logic [31:0]              config_w;
	logic [1:0]               uart_fuse;
	logic                     pad_dis;
	logic                     ujt_dis;

	////////////////////////////////////////////////////////////////////
	// fuse storage; only an APB write to the fuse register programs it
	assign apb_done  = psel_i & penable_i & st_ff.pready;
	assign fuse_prog = apb_done & pwrite_i &
		(paddr_i[11:0] == SBCFG_FUSE_OFS);

	sbcfg_fuse_bank #(
		.W           (SBCFG_FUSE_W)
	) u_fuse (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.prog_i      (fuse_prog),
		.prog_bits_i (pwdata_i[SBCFG_FUSE_W-1:0]),
		.fuse_o      (fuse_q)
	);

	// live fuse fields used by the decode at capture time
	assign uart_fuse = fuse_q[SBCFG_FUSE_UART +: 2];
	assign pad_dis   = fuse_q[SBCFG_FUSE_PADDIS];
	assign ujt_dis   = fuse_q[SBCFG_FUSE_UJTDIS];

	////////////////////////////////////////////////////////////////////
	// read views of the block state
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[SBCFG_STRAP_W-1:0]          = st_ff.strap;
		status_w[SBCFG_ST_VALID]             = st_ff.valid;
		status_w[SBCFG_ST_REL]               = st_ff.release_io;
		status_w[SBCFG_ST_STATE +: 2]        = st_ff.state;
		config_w = 32'h0000_0000;
		config_w[SBCFG_CF_BOOT +: 2]         = st_ff.boot;
		config_w[SBCFG_CF_JTAG +: 2]         = st_ff.jtag;
		config_w[SBCFG_CF_UPRT]              = st_ff.uprt;
		config_w[SBCFG_CF_USBPRT]            = st_ff.usbprt;
		config_w[SBCFG_CF_SMP]               = st_ff.smp;
		config_w[SBCFG_CF_DRV]               = st_ff.drv;
		config_w[SBCFG_CF_DL +: 3]           = st_ff.dl;
		config_w[SBCFG_CF_DBGPIN +: 4]       = st_ff.dbgpin;
	end

	////////////////////////////////////////////////////////////////////
	// next state: synchronisers, power sequence, decode and APB
	always_comb begin
		nxt_st = st_ff;
		// pads pass two flops before anything looks at them
		nxt_st.en_meta  = chip_enable_pin_i;
		nxt_st.en_sync  = st_ff.en_meta;
		nxt_st.pin_meta = {sdio_drive_edge_strap_i,
			sdio_sample_edge_strap_i, debug_source_strap_i,
			boot_strap_b_i, boot_strap_a_i};
		nxt_st.pin_sync = st_ff.pin_meta;

		case (st_ff.state)
			// enable low: chip held in reset, config dropped
			SBCFG_OFF: begin
				nxt_st.valid      = 1'b0;
				nxt_st.release_io = 1'b0;
				nxt_st.pull_up_b  = 1'b1;
				nxt_st.hold_cnt   = '0;
				nxt_st.strap      = SBCFG_STRAP_RST;
				nxt_st.fuse_snap  = SBCFG_FUSE_RST;
				nxt_st.boot       = SBCFG_BOOT_RSVD;
				nxt_st.jtag       = SBCFG_JTAG_OFF;
				nxt_st.dl         = 3'h0;
				nxt_st.smp        = 1'b0;
				nxt_st.drv        = 1'b0;
				nxt_st.uprt       = 1'b0;
				nxt_st.usbprt     = 1'b0;
				nxt_st.dbgpin     = 4'h0;
				if (st_ff.en_sync) begin
					nxt_st.state = SBCFG_HOLD;
				end
			end
			// straps must stay put for the hold time before capture
			SBCFG_HOLD: begin
				nxt_st.hold_cnt = st_ff.hold_cnt + CW'(1);
				if (!st_ff.en_sync) begin
					nxt_st.state = SBCFG_OFF;
				end else if (st_ff.hold_cnt == HOLD_LAST) begin
					// one capture of every strap and fuse, no software
					nxt_st.state      = SBCFG_RUN;
					nxt_st.strap      = st_ff.pin_sync;
					nxt_st.fuse_snap  = fuse_q;
					nxt_st.valid      = 1'b1;
					nxt_st.release_io = 1'b1;
					nxt_st.pull_up_b  = 1'b0; // pins now plain GPIO
					// boot mode
					if (st_ff.pin_sync[SBCFG_STRAP_B]) begin
						nxt_st.boot = SBCFG_BOOT_SPI;
					end else if (st_ff.pin_sync[SBCFG_STRAP_A]) begin
						nxt_st.boot = SBCFG_BOOT_JOINT;
					end else begin
						nxt_st.boot = SBCFG_BOOT_RSVD;
					end
					// download paths open only in joint mode
					nxt_st.dl = (!st_ff.pin_sync[SBCFG_STRAP_B] &&
						st_ff.pin_sync[SBCFG_STRAP_A]) ?
						SBCFG_DL_ALL : 3'h0;
					nxt_st.smp = st_ff.pin_sync[SBCFG_STRAP_SMP];
					nxt_st.drv = st_ff.pin_sync[SBCFG_STRAP_DRV];
					// serial port printing
					case (uart_fuse)
						2'h0: nxt_st.uprt = 1'b1;
						2'h1: nxt_st.uprt =
							~st_ff.pin_sync[SBCFG_STRAP_A];
						2'h2: nxt_st.uprt =
							st_ff.pin_sync[SBCFG_STRAP_A];
						default: nxt_st.uprt = 1'b0;
					endcase
					// usb printing; debug disable overrides
					nxt_st.usbprt = ~fuse_q[SBCFG_FUSE_USBDBG] &
						~fuse_q[SBCFG_FUSE_USBPRT];
					// debug source; the select strap is trusted to be
					// driven, since it has no pull of its own
					if (pad_dis && ujt_dis) begin
						nxt_st.jtag = SBCFG_JTAG_OFF;
					end else if (pad_dis) begin
						nxt_st.jtag = SBCFG_JTAG_USB;
					end else if (ujt_dis) begin
						nxt_st.jtag = SBCFG_JTAG_PADS;
					end else if (fuse_q[SBCFG_FUSE_SELEN]) begin
						nxt_st.jtag = st_ff.pin_sync[SBCFG_STRAP_DBG] ?
							SBCFG_JTAG_USB : SBCFG_JTAG_PADS;
					end else begin
						nxt_st.jtag = SBCFG_JTAG_USB;
					end
					// pin set follows the chosen source, so the two
					// can never disagree
					nxt_st.dbgpin = (nxt_st.jtag == SBCFG_JTAG_PADS) ?
						SBCFG_DBG_ALL : 4'h0;
				end
			end
			// configuration frozen until the enable drops
			SBCFG_RUN: begin
				if (!st_ff.en_sync) begin
					nxt_st.state = SBCFG_OFF;
				end
			end
			default: begin
				nxt_st.state = SBCFG_OFF;
			end
		endcase

		// APB: one wait state, answer registered in the second access cycle
		nxt_st.pready  = psel_i & penable_i & ~st_ff.pready;
		nxt_st.pslverr = 1'b0;
		nxt_st.prdata  = 32'h0000_0000;
		if (psel_i && penable_i && !st_ff.pready) begin
			// straps and config are read only; writes there are dropped
			if (paddr_i[11:0] == SBCFG_STATUS_OFS) begin
				nxt_st.prdata = status_w;
			end else if (paddr_i[11:0] == SBCFG_CONFIG_OFS) begin
				nxt_st.prdata = config_w;
			end else if (paddr_i[11:0] == SBCFG_FUSE_OFS) begin
				nxt_st.prdata = {{(32-SBCFG_FUSE_W){1'b0}}, fuse_q};
			end else if (paddr_i[11:0] == SBCFG_SNAP_OFS) begin
				nxt_st.prdata =
					{{(32-SBCFG_FUSE_W){1'b0}}, st_ff.fuse_snap};
			end else begin
				nxt_st.pslverr = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register; reset takes constants only
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			st_ff            <= '0;
			st_ff.state      <= SBCFG_OFF;
			st_ff.pull_up_b  <= SBCFG_PULLUP_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign boot_strap_b_pull_up_o = st_ff.pull_up_b;
	assign gpio_release_o         = st_ff.release_io;
	assign config_valid_o         = st_ff.valid;
	assign boot_mode_o            = st_ff.boot;
	assign download_paths_o       = st_ff.dl;
	assign sdio_sample_rise_o     = st_ff.smp;
	assign sdio_drive_rise_o      = st_ff.drv;
	assign uart_print_en_o        = st_ff.uprt;
	assign usb_print_en_o         = st_ff.usbprt;
	assign jtag_source_o          = st_ff.jtag;
	assign debug_pins_en_o        = st_ff.dbgpin;
	assign pready_o               = st_ff.pready;
	assign prdata_o               = st_ff.prdata;
	assign pslverr_o              = st_ff.pslverr;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	property p_capture;
		st_ff.state == SBCFG_HOLD && st_ff.en_sync &&
		st_ff.hold_cnt == HOLD_LAST |=> st_ff.valid && st_ff.release_io;
	endproperty
	a_capture: assert property (p_capture)
		else $error("strap capture missed at end of hold");

	property p_enable_low;
		st_ff.en_sync == 1'b0 && st_ff.state != SBCFG_OFF
		|=> st_ff.state == SBCFG_OFF ##1 !st_ff.valid;
	endproperty
	a_enable_low: assert property (p_enable_low)
		else $error("chip enable low did not reset configuration");

	property p_hold_latch;
		st_ff.state == SBCFG_RUN ##1 st_ff.state == SBCFG_RUN
		|-> $stable(st_ff.strap) && $stable(st_ff.boot);
	endproperty
	a_hold_latch: assert property (p_hold_latch)
		else $error("latched strap changed while running");

	property p_no_write;
		st_ff.valid && apb_done && pwrite_i ##1 st_ff.valid
		|-> $stable(config_w);
	endproperty
	a_no_write: assert property (p_no_write)
		else $error("register write altered decoded configuration");

	property p_release;
		st_ff.valid |-> st_ff.release_io && !st_ff.pull_up_b;
	endproperty
	a_release: assert property (p_release)
		else $error("pins not released with valid configuration");

	property p_pullup;
		st_ff.state != SBCFG_RUN && $past(st_ff.state) != SBCFG_RUN
		|-> st_ff.pull_up_b;
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("boot_strap_b pull-up off before capture");

	property p_boot;
		st_ff.valid |-> st_ff.boot == (st_ff.strap[SBCFG_STRAP_B] ?
			SBCFG_BOOT_SPI : st_ff.strap[SBCFG_STRAP_A] ?
			SBCFG_BOOT_JOINT : SBCFG_BOOT_RSVD);
	endproperty
	a_boot: assert property (p_boot)
		else $error("boot mode does not match latched straps");

	property p_paths;
		st_ff.valid |-> (st_ff.dl == SBCFG_DL_ALL) ==
			(st_ff.boot == SBCFG_BOOT_JOINT);
	endproperty
	a_paths: assert property (p_paths)
		else $error("download paths wrong for boot mode");

	property p_edges;
		st_ff.valid |-> st_ff.smp == st_ff.strap[SBCFG_STRAP_SMP] &&
			st_ff.drv == st_ff.strap[SBCFG_STRAP_DRV];
	endproperty
	a_edges: assert property (p_edges)
		else $error("sdio edge select differs from straps");

	property p_uart;
		st_ff.valid && st_ff.fuse_snap[SBCFG_FUSE_UART +: 2] == 2'h3
		|-> !st_ff.uprt;
	endproperty
	a_uart: assert property (p_uart)
		else $error("serial print enabled with fuse value 3");

	property p_usb;
		st_ff.valid |-> st_ff.usbprt ==
			!(st_ff.fuse_snap[SBCFG_FUSE_USBDBG] ||
			st_ff.fuse_snap[SBCFG_FUSE_USBPRT]);
	endproperty
	a_usb: assert property (p_usb)
		else $error("usb print enable wrong for fuses");

	property p_jtag_off;
		st_ff.valid && st_ff.fuse_snap[SBCFG_FUSE_PADDIS] &&
		st_ff.fuse_snap[SBCFG_FUSE_UJTDIS] |-> st_ff.jtag == SBCFG_JTAG_OFF;
	endproperty
	a_jtag_off: assert property (p_jtag_off)
		else $error("debug not disabled with both disable fuses");

	property p_jtag_usb;
		st_ff.valid && st_ff.fuse_snap[SBCFG_FUSE_PADDIS] &&
		!st_ff.fuse_snap[SBCFG_FUSE_UJTDIS] |-> st_ff.jtag == SBCFG_JTAG_USB;
	endproperty
	a_jtag_usb: assert property (p_jtag_usb)
		else $error("debug source not usb with pad disable fuse");

	property p_pins;
		st_ff.valid |-> (st_ff.dbgpin == SBCFG_DBG_ALL) ==
			(st_ff.jtag == SBCFG_JTAG_PADS);
	endproperty
	a_pins: assert property (p_pins)
		else $error("debug pin set does not follow debug source");

	c_spi:   cover property (st_ff.valid && st_ff.boot == SBCFG_BOOT_SPI);
	c_joint: cover property (st_ff.valid && st_ff.boot == SBCFG_BOOT_JOINT);
	c_pads:  cover property (st_ff.valid && st_ff.jtag == SBCFG_JTAG_PADS);
	c_fuse:  cover property (fuse_prog ##1 st_ff.state == SBCFG_OFF);

endmodule

/* testbench/sbcfg_strap_board.sv */
/*
 * board side of the strap pads: pull resistors or a host MCU.
 * assumes the bench sets the level and drive enable of each strap.
 */
`timescale 1ns/1ps

module sbcfg_strap_board (
	// clock
	input  wire logic       clk_i,
	// host drive request
	input  wire logic [4:0] drive_i,
	input  wire logic [4:0] oe_i,
	input  wire logic       pull_up_i,
	// resolved pad levels
	output logic      [4:0] pins_o
);
	logic tog_ff = 1'b0;

	// floating pads wander, so an unpulled pin is never a stable guess
	always_ff @(posedge clk_i) begin
		tog_ff <= ~tog_ff;
	end

	// host holds each strap across reset, undriven b takes its pull-up
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			pins_o[i] = oe_i[i] ? drive_i[i] : tog_ff ^ i[0];
		end
		if (!oe_i[1] && pull_up_i) begin
			pins_o[1] = 1'b1;
		end
	end

endmodule

/* testbench/sbcfg_top_bench.sv */
/*
 * self-checking bench for the strap latch and boot decoder.
 * assumes a short hold count and an APB master on the bench clock.
 */
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
	failures++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
	end end

module sbcfg_top_bench;
	import sbcfg_pkg::*;

	logic        clk_i = 0, reset_n_i = 0, chip_en = 0;
	logic        psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata_o, q;
	logic        pready_o, pslverr_o, err, pull_o, rel_o, valid_o;
	logic [4:0]  drv = 0, oe = 5'h1F, pins;
	logic [1:0]  boot_o, jtag_o;
	logic [2:0]  paths_o;
	logic [3:0]  pins_en_o;
	logic        smp_o, dr_o, up_o, usb_o;
	int          failures = 0, compares = 0, cyc = 0;

	initial forever #50 clk_i = ~clk_i;

	sbcfg_strap_board brd_u (.clk_i(clk_i), .drive_i(drv), .oe_i(oe),
		.pull_up_i(pull_o), .pins_o(pins));

	sbcfg_top #(.HOLD_CYC(8)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.chip_enable_pin_i(chip_en), .boot_strap_a_i(pins[0]),
		.boot_strap_b_i(pins[1]), .debug_source_strap_i(pins[2]),
		.sdio_sample_edge_strap_i(pins[3]),
		.sdio_drive_edge_strap_i(pins[4]), .boot_strap_b_pull_up_o(pull_o),
		.gpio_release_o(rel_o), .config_valid_o(valid_o),
		.boot_mode_o(boot_o), .download_paths_o(paths_o),
		.sdio_sample_rise_o(smp_o), .sdio_drive_rise_o(dr_o),
		.uart_print_en_o(up_o), .usb_print_en_o(usb_o),
		.jtag_source_o(jtag_o), .debug_pins_en_o(pins_en_o),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready_o),
		.prdata_o(prdata_o), .pslverr_o(pslverr_o));

	wire [14:0] outs = {pins_en_o, paths_o, dr_o, smp_o, usb_o, up_o,
		jtag_o, boot_o};

	////////////////////////////////////////////////////////////////////
	// expected config word: pins, paths, drive, sample, usb, uart, jtag, boot
	function automatic logic [14:0] exp_cfg(input logic [4:0] s,
		input logic [6:0] f);
		logic [1:0] bm, jt;
		logic       up;
		bm = s[1] ? 2'h1 : (s[0] ? 2'h2 : 2'h0);
		case (f[1:0])
			2'h0: up = 1'b1;
			2'h1: up = ~s[0];
			2'h2: up = s[0];
			default: up = 1'b0;
		endcase
		if (f[4] & f[5]) jt = 2'h0;
		else if (f[4]) jt = 2'h1;
		else if (f[5]) jt = 2'h2;
		else if (f[6]) jt = s[2] ? 2'h1 : 2'h2;
		else jt = 2'h1;
		return {(jt == 2'h2) ? 4'hF : 4'h0, (bm == 2'h2) ? 3'h7 : 3'h0,
			s[4], s[3], ~(f[2] | f[3]), up, jt, bm};
	endfunction

	// one APB transfer, held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		// no fixed wait assumed; ends when pready is seen, with only the hang guard as a time limit
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		q = prdata_o;
		err = pslverr_o;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task automatic do_reset();
		reset_n_i <= 1'b0; chip_en <= 1'b0;
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
	endtask

	// power up with the given straps, wait for capture
	task automatic power_up(input logic [4:0] s);
		int n;
		n = 0;
		drv <= s;
		@(posedge clk_i);
		chip_en <= 1'b1;
		while (valid_o !== 1'b1 && n < 60) begin
			@(posedge clk_i);
			n++;
		end
		`CHK("valid", 1'b1, valid_o)
		`CHK("release", 1'b1, rel_o)
	endtask

	////////////////////////////////////////////////////////////////////
	// each boot mode, print fuse value and debug source, in nine combinations
	task automatic t_decode();
		logic [4:0] st [9] = '{5'h02, 5'h01, 5'h18, 5'h05, 5'h08,
			5'h10, 5'h03, 5'h00, 5'h01};
		logic [6:0] fu [9] = '{7'h00, 7'h01, 7'h0A, 7'h43, 7'h41,
			7'h10, 7'h24, 7'h30, 7'h02};
		for (int i = 0; i < 9; i++) begin
			do_reset();
			apb(1'b1, SBCFG_FUSE_OFS, {25'h0, fu[i]});
			power_up(st[i]);
			`CHK("outs", exp_cfg(st[i], fu[i]), outs)
			apb(1'b0, SBCFG_CONFIG_OFS, 32'h0);
			`CHK("cfg", {17'h0, exp_cfg(st[i], fu[i])}, q)
			apb(1'b0, SBCFG_SNAP_OFS, 32'h0);
			`CHK("snap", {25'h0, fu[i]}, q)
		end
	endtask

	// latched values survive pad changes, writes and new fuses
	task automatic t_hold();
		logic [14:0] e;
		e = exp_cfg(5'h01, 7'h02);
		drv <= 5'h1E;
		apb(1'b1, SBCFG_CONFIG_OFS, 32'hFFFFFFFF);
		apb(1'b1, SBCFG_FUSE_OFS, 32'h0000007F);
		repeat (6) @(posedge clk_i);
		`CHK("hold", e, outs)
		chip_en <= 1'b0;
		repeat (6) @(posedge clk_i);
		`CHK("off", 1'b0, valid_o)
		`CHK("pull", 1'b1, pull_o)
	endtask

	// fuse bank is one-time, unmapped space errors, b defaults high
	task automatic t_fuse_map();
		do_reset();
		apb(1'b0, SBCFG_FUSE_OFS, 32'h0);
		`CHK("fuse0", 32'h0, q)
		apb(1'b1, SBCFG_FUSE_OFS, 32'h00000001);
		apb(1'b1, SBCFG_FUSE_OFS, 32'h00000002);
		apb(1'b0, SBCFG_FUSE_OFS, 32'h0);
		`CHK("fuse_or", 32'h00000003, q)
		apb(1'b0, 12'h010, 32'h0);
		`CHK("slverr", 1'b1, err)
		oe <= 5'h1D;
		power_up(5'h00);
		`CHK("b_pull", 2'h1, boot_o)
		// status: state run, released, valid, straps with b pulled high
		apb(1'b0, SBCFG_STATUS_OFS, 32'h0);
		`CHK("status", 32'h00000B02, q)
		oe <= 5'h1F;
	endtask

	task automatic close_out();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		t_decode();
		t_hold();
		t_fuse_map();
		close_out();
	end
endmodule
